// [inc/wdt_pkg.sv]
// constants, offsets, states and decode helpers for the runaway watchdog timer
package wdt_pkg;

    // register bus shape
    localparam int unsigned addr_width = 8;
    localparam int unsigned data_width = 32;

    // register byte offsets
    localparam logic [7:0] off_mode = 8'h00;
    localparam logic [7:0] off_clear = 8'h04;
    localparam logic [7:0] off_status = 8'h08;
    localparam logic [7:0] off_mask = 8'h0c;
    localparam logic [7:0] off_count = 8'h10;
    localparam logic [7:0] off_state = 8'h14;
    localparam logic [7:0] off_expiries = 8'h18;

    // watchdog_mode_reg field positions
    localparam int unsigned mode_enable_bit = 0;
    localparam int unsigned mode_period_lsb = 1;
    localparam int unsigned mode_idle_bit = 4;

    // clear register: writing a one here restarts the count
    localparam int unsigned clear_bit = 0;

    // event bits shared by status and mask registers
    localparam int unsigned ev_width = 3;
    localparam int unsigned ev_expiry = 0;
    localparam int unsigned ev_half = 1;
    localparam int unsigned ev_clear_off = 2;

    // values after reset
    localparam logic mode_enable_rst = 1'b1;
    localparam logic [2:0] period_rst = 3'h0;
    localparam logic idle_run_rst = 1'b0;
    localparam logic [2:0] mask_rst = 3'h0;
    localparam logic [2:0] status_rst = 3'h0;
    localparam logic [7:0] expiries_rst = 8'h00;
    localparam logic [24:0] count_rst = 25'h0000000;

    // counter sizing: longest interval is two to the 25th cycles
    localparam int unsigned count_width = 25;
    localparam int unsigned period_exp_min_dflt = 15;
    localparam logic [2:0] period_code_max = 3'h5;

    typedef enum logic [2:0] {
        st_off = 3'b001,
        st_run = 3'b010,
        st_hold = 3'b100
    } wd_state_e;

    // last count value of an interval; codes above the top one act as the top one
    function automatic logic [24:0] interval_last(input logic [2:0] sel,
                                                  input int unsigned exp_min);
        logic [2:0] code;
        int unsigned expo;
        logic [31:0] full;
        code = (sel > period_code_max) ? period_code_max : sel;
        expo = exp_min + 2 * int'(code);
        full = (32'h00000001 << expo) - 32'h00000001;
        return full[24:0];
    endfunction

endpackage

// [hdl/wdt_counter.sv]
// binary counter of system clock cycles with expiry and halfway pulses
`timescale 1ns/1ps
module wdt_counter
    import wdt_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic run, // advance the count this cycle
    input wire logic clear, // restart the count from zero
    input wire logic [24:0] last, // last count of the selected interval
    output logic [24:0] count, // present count
    output logic expire, // one-cycle pulse, interval elapsed
    output logic half_hit // one-cycle pulse, half of interval reached
);

    logic at_end;
    logic [24:0] half;

    // compare with >= so that shortening the interval mid-count still expires
    assign at_end = (count >= last);
    assign half = last >> 1;

    // the count itself, fed only by the system clock
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= count_rst;
        end else if (ce) begin
            if (clear) begin
                count <= count_rst;
            end else if (run) begin
                if (at_end) begin
                    count <= count_rst;
                end else begin
                    count <= count + 25'h0000001;
                end
            end
        end
    end

    // expiry and halfway pulses, suppressed by a clear in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            expire <= 1'b0;
            half_hit <= 1'b0;
        end else if (ce) begin
            expire <= run && !clear && at_end;
            half_hit <= run && !clear && !at_end && (count == half);
        end
    end

endmodule

// [hdl/runaway_watchdog_timer.sv]
// runaway watchdog timer: register slave, run control and expiry signalling
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - counts system clock cycles in a binary counter, no other clock
// - three-bit select picks interval two to the 15, 17, 19, 21, 23 or 25
// - counter reaching the interval raises the expiry request
// - expiry request goes out as a non-maskable interrupt when not cleared
// - watchdog runs straight out of reset, no software enable needed
// - in idle the counter runs or holds per the idle-run enable bit
// - counter freezes during debug and resumes when debug ends
// - no timeout output pin; expiry shows only as interrupt request
module runaway_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int unsigned period_exp_min = period_exp_min_dflt // shortest exponent
)
(
    input wire logic clk, // system clock, 200 mhz
    input wire logic resetn, // async reset, active low
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic [7:0] addr, // register byte address
    input wire logic [31:0] wdata, // register write data
    input wire logic wr, // write strobe, one cycle
    input wire logic rd, // read strobe, one cycle
    output logic [31:0] rdata, // read data, valid the cycle after rd
    input wire logic idle_mode, // core is in idle, same clock domain
    input wire logic debug_mode, // core is halted in debug, same clock domain
    output logic watchdog_expiry_irq, // non-maskable request, one-cycle pulse
    output logic irq // maskable level interrupt from status bits
);

    // mode register fields
    logic wd_enable;
    logic [2:0] timeout_period_select;
    logic idle_run_enable;

    // interrupt bookkeeping
    logic [2:0] status;
    logic [2:0] next_status;
    logic [2:0] mask;
    logic [2:0] ev_set;
    logic [2:0] ev_clr;

    // run control
    wd_state_e state;
    wd_state_e next_state;
    logic run;
    logic sw_clear;
    logic cnt_clear;

    // counter interface
    logic [24:0] last;
    logic [24:0] count;
    logic expire;
    logic half_hit;

    // saturating tally of expiries
    logic [7:0] expiries;

    // decoded write strobes
    logic wr_mode;
    logic wr_clear;
    logic wr_status;
    logic wr_mask;
    logic wr_expiries;

    assign wr_mode = wr && (addr == off_mode);
    assign wr_clear = wr && (addr == off_clear);
    assign wr_status = wr && (addr == off_status);
    assign wr_mask = wr && (addr == off_mask);
    assign wr_expiries = wr && (addr == off_expiries);

    // mode register; enable is set at reset so the dog bites unless turned off
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wd_enable <= mode_enable_rst;
            timeout_period_select <= period_rst;
            idle_run_enable <= idle_run_rst;
        end else if (ce && wr_mode) begin
            wd_enable <= wdata[mode_enable_bit];
            timeout_period_select <= wdata[mode_period_lsb +: 3];
            idle_run_enable <= wdata[mode_idle_bit];
        end
    end

    // mask register, same layout as status
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask <= mask_rst;
        end else if (ce && wr_mask) begin
            mask <= wdata[ev_width-1:0];
        end
    end

    // run state: off when disabled, hold in debug or in idle without idle-run
    always_comb begin
        next_state = st_run;
        if (!wd_enable) begin
            next_state = st_off;
        end else if (debug_mode) begin
            next_state = st_hold;
        end else if (idle_mode && !idle_run_enable) begin
            next_state = st_hold;
        end else begin
            next_state = st_run;
        end
    end

    // state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= st_run;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // count only while running; hold keeps the count, off forces it to zero
    always_comb begin
        run = 1'b0;
        case (state)
            st_run: run = 1'b1;
            st_hold: run = 1'b0;
            st_off: run = 1'b0;
            default: run = 1'b0;
        endcase
    end

    // zeroing while off means re-enabling always starts a full interval
    assign sw_clear = wr_clear && wdata[clear_bit];
    assign cnt_clear = sw_clear || (state == st_off);

    // interval decode from the period select field
    assign last = interval_last(timeout_period_select, period_exp_min);

    wdt_counter u_counter (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .run(run),
        .clear(cnt_clear),
        .last(last),
        .count(count),
        .expire(expire),
        .half_hit(half_hit)
    );

    // event sources feeding the sticky status bits
    always_comb begin
        ev_set = 3'h0;
        ev_set[ev_expiry] = expire;
        ev_set[ev_half] = half_hit;
        ev_set[ev_clear_off] = sw_clear && (state == st_off);
    end

    // write one to clear; a set in the same cycle wins over the clear
    always_comb begin
        ev_clr = wr_status ? wdata[ev_width-1:0] : 3'h0;
        next_status = (status & ~ev_clr) | ev_set;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status <= status_rst;
        end else if (ce) begin
            status <= next_status;
        end
    end

    // level interrupt follows status in the same cycle it changes, and a mask write one cycle later
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(next_status & mask);
        end
    end

    // non-maskable request: no mask or enable gate on purpose, the core
    // must see a runaway even if software corrupted the mask register;
    // this is the only non-maskable expiry signal, there is no timeout pin
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            watchdog_expiry_irq <= 1'b0;
        end else if (ce) begin
            watchdog_expiry_irq <= expire;
        end
    end

    // expiry tally saturates so software can tell repeated runaways apart
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            expiries <= expiries_rst;
        end else if (ce) begin
            if (expire && (expiries != 8'hff)) begin
                expiries <= expiries + 8'h01;
            end else if (wr_expiries && !expire) begin
                expiries <= expiries_rst;
            end
        end
    end

    // read port: data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h00000000;
        end else if (ce) begin
            if (rd) begin
                case (addr)
                    off_mode: rdata <= {27'h0000000, idle_run_enable,
                                        timeout_period_select, wd_enable};
                    off_clear: rdata <= 32'h00000000;
                    off_status: rdata <= {29'h00000000, status};
                    off_mask: rdata <= {29'h00000000, mask};
                    off_count: rdata <= {7'h00, count};
                    off_state: rdata <= {29'h00000000, state};
                    off_expiries: rdata <= {24'h000000, expiries};
                    default: rdata <= 32'h00000000;
                endcase
            end else begin
                rdata <= 32'h00000000;
            end
        end
    end

endmodule

// [tb/wdt_assertions.sv]
// assertion checker for the runaway watchdog timer ports
`timescale 1ns/1ps
module wdt_assertions
    import wdt_pkg::*;
#(
    parameter int unsigned period_exp_min = 2 // shortest exponent
)
(
    input wire logic clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic [7:0] addr, // register address
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    input wire logic [31:0] rdata, // read data
    input wire logic idle_mode, // core idle
    input wire logic debug_mode, // core in debug
    input wire logic watchdog_expiry_irq, // non-maskable request
    input wire logic irq // maskable level interrupt
);
    logic en_q; // shadow of the enable bit
    logic idle_q; // shadow of the idle-run bit
    logic [2:0] sel_q; // shadow of the period select
    logic calm; // nothing disturbed the count since reset
    logic [3:0] cyc; // edges since reset, saturating
    logic quiet;
    logic fast;
    logic clr_wr;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // counting undisturbed: no write, no freeze
    assign quiet = ce && !wr && !debug_mode && (!idle_mode || idle_q);
    // timing figures below hold for the shortest interval only
    assign fast = en_q && sel_q == 3'h0 && period_exp_min == 2;
    assign clr_wr = ce && wr && addr == off_clear && wdata[clear_bit] && fast && quiet == 1'b0
        && !debug_mode && (!idle_mode || idle_q);
    // shadow the mode fields; only writes move them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            en_q <= mode_enable_rst;
            sel_q <= period_rst;
            idle_q <= idle_run_rst;
        end else if (ce && wr && addr == off_mode) begin
            en_q <= wdata[mode_enable_bit];
            sel_q <= wdata[mode_period_lsb +: 3];
            idle_q <= wdata[mode_idle_bit];
        end
    end
    // age since reset, and whether it ran free all along
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cyc <= 4'h0;
            calm <= 1'b1;
        end else begin
            cyc <= (cyc == 4'hf) ? cyc : cyc + 4'h1;
            calm <= calm && quiet;
        end
    end
    sequence s_free3;
        quiet[*3];
    endsequence
    sequence s_seen;
        quiet && watchdog_expiry_irq && fast;
    endsequence
    AST_NMI_PULSE: assert property (watchdog_expiry_irq && ce |=> !watchdog_expiry_irq)
        else $error("expiry request longer than one cycle");
    AST_NMI_GAP: assert property (watchdog_expiry_irq && ce ##1 ce |=> !watchdog_expiry_irq)
        else $error("expiry requests too close");
    AST_PERIOD: assert property (quiet[*2] ##1 s_seen ##1 s_free3 |=> watchdog_expiry_irq)
        else $error("expiry interval wrong");
    AST_FIRST: assert property (calm && fast && cyc <= 4'h5 |-> watchdog_expiry_irq == (cyc == 4'h5))
        else $error("first expiry after reset at wrong cycle");
    AST_DEBUG: assert property ((debug_mode && ce)[*3] |=> !watchdog_expiry_irq)
        else $error("expiry during debug");
    AST_IDLE: assert property ((idle_mode && !idle_q && ce && !wr)[*3] |=> !watchdog_expiry_irq)
        else $error("expiry while idle hold");
    AST_OFF: assert property ((!en_q && ce)[*3] |=> !watchdog_expiry_irq)
        else $error("expiry while disabled");
    AST_CLEAR: assert property (clr_wr ##1 s_free3 ##1 quiet |=> !watchdog_expiry_irq ##1 watchdog_expiry_irq)
        else $error("count did not restart from zero");
endmodule

bind runaway_watchdog_timer wdt_assertions #(.period_exp_min(period_exp_min)) chk (
    .clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .idle_mode(idle_mode), .debug_mode(debug_mode),
    .watchdog_expiry_irq(watchdog_expiry_irq), .irq(irq));

// [tb/core_model.sv]
// processor core stand-in that takes the non-maskable expiry request
`timescale 1ns/1ps
module core_model (
    input wire logic clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic watchdog_expiry_irq, // request from the watchdog
    output logic [15:0] nmi_count // requests taken so far
);
    // every high cycle is one request; it cannot be masked here
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nmi_count <= 16'h0000;
        end else if (watchdog_expiry_irq) begin
            nmi_count <= nmi_count + 16'h0001;
        end
    end
endmodule

// [tb/testbench.sv]
// self-checking testbench for the runaway watchdog timer
`timescale 1ns/1ps
module testbench;
    import wdt_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
    logic idle_mode = 1'b0, debug_mode = 1'b0, watchdog_expiry_irq, irq;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [15:0] nmi_count, n0;
    int num_errors = 0, n_tests = 0, cycles = 0;
    runaway_watchdog_timer #(.period_exp_min(2)) uut (.clk(clk), .resetn(resetn), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .idle_mode(idle_mode),
        .debug_mode(debug_mode), .watchdog_expiry_irq(watchdog_expiry_irq), .irq(irq));
    core_model core (.clk(clk), .resetn(resetn), .watchdog_expiry_irq(watchdog_expiry_irq),
        .nmi_count(nmi_count));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic stop_test;
        $display("errors %0d in %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // cut a hang short; the full run needs about 14000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    // disable first so the count starts from zero, then enable
    task automatic arm(input logic [31:0] mode);
        wr_reg(off_mode, 32'h0);
        repeat (3) @(posedge clk);
        #1;
        n0 = nmi_count;
        wr_reg(off_mode, mode);
    endtask
    task automatic expect_nmi(input int len);
        repeat (len + 2) @(posedge clk);
        #1;
        check({16'h0000, nmi_count}, {16'h0000, n0});
        @(posedge clk);
        #1;
        check({16'h0000, nmi_count}, {16'h0000, n0 + 16'h0001});
    endtask
    initial begin
        int len;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(off_mode, 32'h1);
        repeat (34) @(posedge clk);
        wr_reg(off_mode, 32'h0);
        #1;
        check({16'h0000, nmi_count}, 32'h9);
        rd_chk(off_status, 32'h3);
        wr_reg(off_mask, 32'h1);
        rd_chk(off_state, 32'h1);
        check({31'h0, irq}, 32'h1);
        wr_reg(off_status, 32'h1);
        rd_chk(off_status, 32'h2);
        check({31'h0, irq}, 32'h0);
        wr_reg(off_clear, 32'h1);
        wr_reg(off_mask, 32'h4);
        rd_chk(off_count, 32'h0);
        check({31'h0, irq}, 32'h1);
        rd_chk(8'h1c, 32'h0);
        rd_chk(off_expiries, 32'h9);
        // every select code; codes above five act as five; ce stall once
        for (int s = 0; s < 8; s++) begin
            len = 1 << (2 + 2 * ((s > 5) ? 5 : s));
            arm({28'h0000000, 3'(s), 1'b1});
            if (s == 5) begin
                ce <= 1'b0;
                repeat (100) @(posedge clk);
                ce <= 1'b1;
            end
            expect_nmi(len);
        end
        arm(32'h1);
        repeat (20) wr_reg(off_clear, 32'h1);
        // count already runs at the clear edge, so one cycle less than after arm
        expect_nmi(3);
        // debug freeze, idle hold, then idle with run enabled
        for (int k = 0; k < 3; k++) begin
            arm((k == 2) ? 32'h11 : 32'h1);
            debug_mode <= (k == 0);
            idle_mode <= (k != 0);
            if (k < 2) begin
                repeat (30) @(posedge clk);
                debug_mode <= 1'b0;
                idle_mode <= 1'b0;
            end
            expect_nmi(4);
        end
        stop_test();
    end
endmodule
